// ===== baud_counter.sv
// Baud counter: down-counter reloaded from the divisor, one tick per expiry except in a restart cycle.
// Assumes restart and divisor come from logic on the same clock.
module baud_counter #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstnSync,
  // Control
  input wire logic [DIV_W-1:0] divisor,
  input wire logic restart,
  // Timing
  output logic tick
);

  logic [DIV_W-1:0] count_r;
  wire expired = (count_r == '0);

  // A divisor write restarts counting from the new value [RULE5]
  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      count_r <= '0;
    end else if (restart || expired) begin
      count_r <= divisor; // [RULE6]
    end else begin
      count_r <= count_r - 1'b1;
    end
  end

  assign tick = expired && !restart; // [RULE6]

endmodule // baud_counter

// ===== remote_peer.sv
// Remote serial transceiver on the line side of the block.
// Assumes 8N1 frames or a ninth bit before the stop bit, LSB first;
// samples on the falling clock edge.
module remote_peer (
  // Clock
  input wire logic clk,
  // Serial line
  output logic rxLine,
  input wire logic txLine
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rxLine = 1'b1;
  // Called just after a rising edge; idles at the mark level afterwards
  task automatic send(input logic [7:0] b, input int bitClks);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxLine <= f[i];
      repeat (bitClks) @(posedge clk);
    end
  endtask
  // Frame with a ninth data bit ahead of the stop bit
  task automatic sendNinth(input logic [8:0] c, input int bitClks);
    logic [10:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxLine <= f[i];
      repeat (bitClks) @(posedge clk);
    end
  endtask
  // Bit time is taken from the start bit, so bit 0 of b must be 1
  task automatic recv(output logic [7:0] b, output int startLen);
    startLen = 0;
    while (txLine) @(negedge clk);
    while (!txLine) begin
      startLen++;
      @(negedge clk);
    end
    repeat (startLen / 2) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      b[i] = txLine;
      repeat (startLen) @(negedge clk);
    end
  endtask
endmodule // remote_peer

// ===== serial_data_regs.sv
// Data path registers of an asynchronous serial transceiver with its
// shifters. Assumes software on an 8-bit strobe port and a remote peer on
// the serial line; rxLine is asynchronous and synchronised here.
// Behaviour
// RULE1: Receive register shows received low eight bits; ninth bit sits in status.
// RULE2: Received character and ninth bit stay readable while next one shifts.
// RULE3: Transmit register with ninth bit accepts writes once shifting has begun.
// RULE4: Low divisor byte is read/write and clears to zero on reset.
// RULE5: Writing the low divisor byte restarts the baud counter.
// RULE6: Baud counter reloads on expiry; each expiry times both shifters. An expiry in the cycle of a divisor write gives no tick.
module serial_data_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [serial_regs_pkg::ADDR_W-1:0] regAddr,
  input wire logic [serial_regs_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [serial_regs_pkg::DATA_W-1:0] regRdData,
  // Serial line
  input wire logic rxLine,
  output logic txLine
);

  logic rstnMeta_r, rstnSync;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstnMeta_r <= 1'b0;
      rstnSync <= 1'b0;
    end else begin
      rstnMeta_r <= 1'b1;
      rstnSync <= rstnMeta_r;
    end
  end

  logic rxMeta_r, rxIn_r;
  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      rxMeta_r <= 1'b1;
      rxIn_r <= 1'b1;
    end else begin
      rxMeta_r <= rxLine;
      rxIn_r <= rxMeta_r;
    end
  end

  function automatic logic sel(input logic [serial_regs_pkg::ADDR_W-1:0] a,
                               input logic [serial_regs_pkg::ADDR_W-1:0] b);
    sel = (a == b);
  endfunction

  // Register decode
  wire wrTx = regWr && sel(regAddr, serial_regs_pkg::IDX_TRANSMIT_HOLDING);
  wire wrBaud = regWr && sel(regAddr, serial_regs_pkg::IDX_BAUD_DIVISOR_LOW);
  wire wrStat = regWr && sel(regAddr, serial_regs_pkg::IDX_LINE_STATUS);
  wire rdRecv = regRd && sel(regAddr, serial_regs_pkg::IDX_RECEIVE_HOLDING);

  logic [7:0] baudDivisorLow_r;
  logic ninthEn_r, txNinth_r, overrun_r, frameErr_r;
  logic tick;

  // Divisor clears to zero at reset [RULE4]
  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      baudDivisorLow_r <= serial_regs_pkg::RESET_BYTE;
      ninthEn_r <= 1'b0;
      txNinth_r <= 1'b0;
    end else begin
      if (wrBaud) baudDivisorLow_r <= regWrData; // [RULE4]
      if (wrStat) begin
        ninthEn_r <= regWrData[serial_regs_pkg::CT_NINTH_EN];
        txNinth_r <= regWrData[serial_regs_pkg::CT_TX_NINTH];
      end
    end
  end

  baud_counter #(.DIV_W(8)) u_baud (
    .clk(clk),
    .rstnSync(rstnSync),
    .divisor(wrBaud ? regWrData : baudDivisorLow_r),
    .restart(wrBaud), // [RULE5]
    .tick(tick)
  );

  // Transmit side: holding buffer in front of the shifter
  serial_regs_pkg::serChar_t txHold_r, txShift_r;
  logic txFull_r;
  serial_regs_pkg::lineState_t txState_r;
  logic [3:0] txTick_r;
  logic [2:0] txBit_r;

  wire txIdle = (txState_r == serial_regs_pkg::LN_IDLE);
  wire txLoad = txIdle && txFull_r;
  wire txBitEnd = tick && (txTick_r == serial_regs_pkg::TICK_LAST);
  // A write while the buffer still holds an unsent byte is dropped
  wire txAccept = wrTx && (!txFull_r || txLoad); // [RULE3]

  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      txHold_r <= '0;
      txFull_r <= 1'b0;
    end else begin
      if (txAccept) begin
        txHold_r <= '{ninth: txNinth_r, data: regWrData}; // [RULE3]
      end
      txFull_r <= txAccept || (txFull_r && !txLoad);
    end
  end

  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      txState_r <= serial_regs_pkg::LN_IDLE;
      txShift_r <= '0;
      txTick_r <= '0;
      txBit_r <= '0;
      txLine <= 1'b1;
    end else begin
      if (tick) txTick_r <= txTick_r + 1'b1; // [RULE6]
      case (txState_r)
        serial_regs_pkg::LN_IDLE: begin
          txLine <= 1'b1;
          if (txLoad) begin
            txShift_r <= txHold_r; // [RULE3]
            txState_r <= serial_regs_pkg::LN_START;
            txTick_r <= '0;
            txLine <= 1'b0;
          end
        end
        serial_regs_pkg::LN_START: begin
          if (txBitEnd) begin
            txState_r <= serial_regs_pkg::LN_DATA;
            txBit_r <= '0;
            txLine <= txShift_r.data[0];
          end
        end
        serial_regs_pkg::LN_DATA: begin
          if (txBitEnd) begin
            txBit_r <= txBit_r + 1'b1;
            if (txBit_r == serial_regs_pkg::BIT_LAST) begin
              txState_r <= ninthEn_r ? serial_regs_pkg::LN_NINTH
                                     : serial_regs_pkg::LN_STOP;
              txLine <= ninthEn_r ? txShift_r.ninth : 1'b1;
            end else begin
              txLine <= txShift_r.data[txBit_r + 3'h1];
            end
          end
        end
        serial_regs_pkg::LN_NINTH: begin
          if (txBitEnd) begin
            txState_r <= serial_regs_pkg::LN_STOP;
            txLine <= 1'b1;
          end
        end
        serial_regs_pkg::LN_STOP: begin
          if (txBitEnd) txState_r <= serial_regs_pkg::LN_IDLE;
        end
        default: txState_r <= serial_regs_pkg::LN_IDLE;
      endcase
    end
  end

  // Receive side: shifter feeding a holding register
  serial_regs_pkg::serChar_t rxShift_r, receiveHolding_r;
  logic rxReady_r;
  serial_regs_pkg::lineState_t rxState_r;
  logic [3:0] rxTick_r;
  logic [2:0] rxBit_r;
  logic rxDone, rxStopBad;

  wire rxBitEnd = tick && (rxTick_r == serial_regs_pkg::TICK_LAST);
  wire rxMid = tick && (rxTick_r == serial_regs_pkg::TICK_HALF);

  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      rxState_r <= serial_regs_pkg::LN_IDLE;
      rxShift_r <= '0;
      rxTick_r <= '0;
      rxBit_r <= '0;
    end else begin
      if (tick) rxTick_r <= rxTick_r + 1'b1; // [RULE6]
      case (rxState_r)
        serial_regs_pkg::LN_IDLE: begin
          if (tick && !rxIn_r) begin
            rxState_r <= serial_regs_pkg::LN_START;
            rxTick_r <= '0;
          end
        end
        serial_regs_pkg::LN_START: begin
          // Realign so later samples land mid-bit; a glitch aborts
          if (rxMid) begin
            rxState_r <= rxIn_r ? serial_regs_pkg::LN_IDLE
                                : serial_regs_pkg::LN_DATA;
            rxTick_r <= '0;
            rxBit_r <= '0;
          end
        end
        serial_regs_pkg::LN_DATA: begin
          if (rxBitEnd) begin
            rxShift_r.data <= {rxIn_r, rxShift_r.data[7:1]};
            rxBit_r <= rxBit_r + 1'b1;
            if (rxBit_r == serial_regs_pkg::BIT_LAST) begin
              rxState_r <= ninthEn_r ? serial_regs_pkg::LN_NINTH
                                     : serial_regs_pkg::LN_STOP;
            end
          end
        end
        serial_regs_pkg::LN_NINTH: begin
          if (rxBitEnd) begin
            rxShift_r.ninth <= rxIn_r;
            rxState_r <= serial_regs_pkg::LN_STOP;
          end
        end
        serial_regs_pkg::LN_STOP: begin
          if (rxBitEnd) rxState_r <= serial_regs_pkg::LN_IDLE;
        end
        default: rxState_r <= serial_regs_pkg::LN_IDLE;
      endcase
    end
  end

  assign rxDone = rxBitEnd && (rxState_r == serial_regs_pkg::LN_STOP);
  assign rxStopBad = rxDone && !rxIn_r;

  // Holding register only changes when the previous byte was consumed, so
  // software never sees a half-shifted byte; a late reader loses the new one
  wire rxTake = rxDone && (!rxReady_r || rdRecv);
  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      receiveHolding_r <= '0;
      rxReady_r <= 1'b0;
      overrun_r <= 1'b0;
      frameErr_r <= 1'b0;
    end else begin
      if (rxTake) begin
        receiveHolding_r <= '{ninth: ninthEn_r & rxShift_r.ninth,
                              data: rxShift_r.data}; // [RULE2]
      end
      rxReady_r <= rxDone || (rxReady_r && !rdRecv); // [RULE2]
      overrun_r <= (rxDone && !rxTake) ||
                   (overrun_r &&
                    !(wrStat && regWrData[serial_regs_pkg::ST_OVERRUN]));
      frameErr_r <= rxStopBad ||
                    (frameErr_r &&
                     !(wrStat && regWrData[serial_regs_pkg::ST_FRAME_ERR]));
    end
  end

  // Read mux, answered in the cycle after the strobe
  logic [7:0] lineStatus;
  always_comb begin
    lineStatus = '0;
    lineStatus[serial_regs_pkg::ST_RX_READY] = rxReady_r;
    lineStatus[serial_regs_pkg::ST_RX_NINTH] = receiveHolding_r.ninth;
    lineStatus[serial_regs_pkg::ST_TX_EMPTY] = !txFull_r;
    lineStatus[serial_regs_pkg::ST_OVERRUN] = overrun_r;
    lineStatus[serial_regs_pkg::ST_FRAME_ERR] = frameErr_r;
    lineStatus[serial_regs_pkg::CT_NINTH_EN] = ninthEn_r;
    lineStatus[serial_regs_pkg::CT_TX_NINTH] = txNinth_r;
  end

  wire [7:0] rdMux =
    sel(regAddr, serial_regs_pkg::IDX_RECEIVE_HOLDING) ?
      receiveHolding_r.data : // [RULE1]
    sel(regAddr, serial_regs_pkg::IDX_TRANSMIT_HOLDING) ? txHold_r.data :
    sel(regAddr, serial_regs_pkg::IDX_BAUD_DIVISOR_LOW) ? baudDivisorLow_r :
    lineStatus;

  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      regRdData <= '0;
    end else begin
      regRdData <= regRd ? rdMux : '0;
    end
  end

endmodule // serial_data_regs

// ===== serial_regs_monitor.sv
// Checker for the serial data register block, bound to its top module.
// Assumes single-cycle strobes that are never both high.
module serial_regs_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [serial_regs_pkg::ADDR_W-1:0] regAddr,
  input wire logic [serial_regs_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [serial_regs_pkg::DATA_W-1:0] regRdData,
  // Serial line
  input wire logic rxLine,
  input wire logic txLine
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic txSeen_r;
  logic divSeen_r;
  wire txWr = regWr && regAddr == serial_regs_pkg::IDX_TRANSMIT_HOLDING;
  wire divWr = regWr && regAddr == serial_regs_pkg::IDX_BAUD_DIVISOR_LOW;
  wire wrAny = txWr || divWr;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txSeen_r <= 1'b0;
      divSeen_r <= 1'b0;
    end else begin
      txSeen_r <= txSeen_r | txWr;
      divSeen_r <= divSeen_r | divWr;
    end
  end
  a_rd_idle_zero: assert property (
    !$past(regRd) |-> regRdData == 8'h00) else $error("stray read data");
  a_div_reset_zero: assert property (
    regRd && !divSeen_r && regAddr == serial_regs_pkg::IDX_BAUD_DIVISOR_LOW
    |=> regRdData == 8'h00) else $error("divisor not zero after reset");
  a_wr_read_back: assert property (
    wrAny ##1 regRd && regAddr == $past(regAddr)
    |=> regRdData == $past(regWrData, 2)) else $error("read back differs");
  a_tx_idle_high: assert property (
    !txSeen_r |-> txLine) else $error("line left idle before a write");
  a_tx_first_start: assert property (
    txWr && !txSeen_r |-> ##[1:600] !txLine) else $error("no start bit");
  a_start_bit_min: assert property (
    $fell(txLine) |-> !txLine [*8]) else $error("start bit too short");
endmodule // serial_regs_checker

bind serial_data_regs serial_regs_checker i_chk (
  .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .rxLine(rxLine), .txLine(txLine)
);

// ===== serial_regs_pkg.sv
// Shared constants and types for the serial data and baud register block.
// Assumes one 20 MHz system clock and an 8-bit register port.
package serial_regs_pkg;

  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;

  // Register indices on the register port
  localparam logic [ADDR_W-1:0] IDX_RECEIVE_HOLDING = 2'h0;
  localparam logic [ADDR_W-1:0] IDX_TRANSMIT_HOLDING = 2'h1;
  localparam logic [ADDR_W-1:0] IDX_BAUD_DIVISOR_LOW = 2'h2;
  localparam logic [ADDR_W-1:0] IDX_LINE_STATUS = 2'h3;

  // Reset values
  localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;

  // Line status / control bit positions
  localparam int ST_RX_READY = 0;
  localparam int ST_RX_NINTH = 1;
  localparam int ST_TX_EMPTY = 2;
  localparam int ST_OVERRUN = 3;
  localparam int ST_FRAME_ERR = 4;
  localparam int CT_NINTH_EN = 5;
  localparam int CT_TX_NINTH = 6;

  // Baud ticks per bit time and the mid-bit sample point
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_HALF = 4'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // One character: eight data bits and the ninth bit
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } serChar_t;

  typedef enum logic [2:0] {
    LN_IDLE = 3'b000,
    LN_START = 3'b001,
    LN_DATA = 3'b010,
    LN_NINTH = 3'b011,
    LN_STOP = 3'b100
  } lineState_t;

endpackage

// ===== tb_top.sv
// Self-checking bench for the serial data register block.
// Assumes a 20 MHz clock and the remote peer model on the line.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rstn, regWr, regRd;
  logic [1:0] regAddr;
  logic [7:0] regWrData, d, b1, b2;
  wire logic [7:0] regRdData;
  wire logic rxLine, txLine;
  int numErrors = 0;
  int checkCount = 0;
  int cycles = 0;
  int len;
  always #25 clk = ~clk;
  serial_data_regs i_dut (.clk(clk), .rstn(rstn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .rxLine(rxLine), .txLine(txLine));
  remote_peer i_peer (.clk(clk), .rxLine(rxLine), .txLine(txLine));
  task automatic check(input logic [7:0] got, exp, input string m);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic finishTest();
    $display("checks %0d mismatches %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      numErrors++;
      finishTest();
    end
  end
  // Tasks start and end just after a rising edge
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  // Two writes back to back; the strobe stays high between them
  task automatic wr2(input logic [1:0] a1, input logic [7:0] v1,
                     input logic [1:0] a2, input logic [7:0] v2);
    regAddr <= a1;
    regWrData <= v1;
    regWr <= 1'b1;
    @(posedge clk);
    regAddr <= a2;
    regWrData <= v2;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 v = regRdData;
    @(posedge clk);
  endtask
  task automatic waitStatus(input int pos);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 2000 && s[pos] !== 1'b1; i++) rd(2'h3, s);
  endtask
  task automatic testReset();
    for (int a = 0; a < 3; a++) begin
      rd(a[1:0], d);
      check(d, 8'h00, "reset value");
    end
    rd(2'h3, d);
    check(d, 8'h04, "reset status");
    wr(2'h2, 8'h5a);
    rd(2'h2, d);
    check(d, 8'h5a, "divisor");
    wr(2'h0, 8'hff);
    rd(2'h0, d);
    check(d, 8'h00, "receive is read only");
    $display("reset and register test done");
  endtask
  // Second byte is written as soon as the first has begun shifting. The
  // divisor write right before the first byte fixes the tick phase, so
  // only a restarted counter gives a first start bit of 16 two-clock ticks;
  // later start bits may lose part of a tick to the load cycle.
  task automatic testTx();
    wr2(2'h2, 8'h01, 2'h1, 8'ha5);
    fork
      begin
        i_peer.recv(b1, len);
        check(len[7:0], 8'd32, "bit time");
        i_peer.recv(b2, len);
      end
      begin
        rd(2'h1, d);
        check(d, 8'ha5, "transmit read back");
        waitStatus(serial_regs_pkg::ST_TX_EMPTY);
        wr(2'h1, 8'h3b);
      end
    join
    check(b1, 8'ha5, "first byte");
    check(b2, 8'h3b, "second byte");
    $display("transmit test done");
  endtask
  // First byte must stay readable while the second shifts in
  task automatic testRx();
    i_peer.send(8'h6c, 32);
    waitStatus(serial_regs_pkg::ST_RX_READY);
    fork
      i_peer.send(8'h93, 32);
    join_none
    repeat (160) @(posedge clk);
    rd(2'h0, d);
    check(d, 8'h6c, "held byte");
    waitStatus(serial_regs_pkg::ST_RX_READY);
    rd(2'h0, d);
    check(d, 8'h93, "next byte");
    $display("receive test done");
  endtask
  // Ninth bit lands in the status register beside the received byte
  task automatic testNinth();
    // Let the peer finish the stop bit of the previous frame first
    repeat (40) @(posedge clk);
    wr(2'h3, 8'h20);
    i_peer.sendNinth(9'h1c3, 32);
    waitStatus(serial_regs_pkg::ST_RX_READY);
    rd(2'h3, d);
    check(d, 8'h27, "ninth bit status");
    rd(2'h0, d);
    check(d, 8'hc3, "ninth mode byte");
    wr(2'h3, 8'h00);
    $display("ninth bit test done");
  endtask
  initial begin
    rstn = 1'b0;
    regAddr = 2'h0;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    testReset();
    testTx();
    testRx();
    testNinth();
    finishTest();
  end
endmodule // tb_top
